/* File: design/fault_report_pkg.sv */
// Constants shared by the output-module fault and status reporter
package fault_report_pkg;

	// ======================================================================
	// Sizes
	// ======================================================================
	localparam int CH_COUNT = 8;       // 4 or 8 channel variant
	localparam int WORD_W   = 16;
	localparam int LEVEL_W  = 24;      // Signed output level, 16 fraction bits
	localparam int PROD_W   = 56;

	// ======================================================================
	// Summary word bit positions
	// ======================================================================
	localparam int SUM_GROUP_BIT = 15;
	localparam int SUM_CAL_BUSY  = 12;
	localparam int SUM_CAL_ERR   = 11;

	// ======================================================================
	// Floating point per-channel status word bit positions
	// ======================================================================
	localparam int ST_HIGH_BIT = 0;
	localparam int ST_LOW_BIT  = 1;
	localparam int ST_RATE_BIT = 2;
	localparam int ST_HOLD_BIT = 3;
	localparam int ST_CAL_BIT  = 4;
	localparam int ST_NAN_BIT  = 5;
	localparam int ST_OPEN_BIT = 7;

	// Integer mode packed status word: channel c uses bits 15-2c and 14-2c
	localparam int INT_OPEN_TOP = 15;
	localparam int INT_HOLD_TOP = 14;

	// ======================================================================
	// Forced channel fault word values and reset values
	// ======================================================================
	localparam logic [WORD_W-1:0] CAL_FORCE_WORD  = WORD_W'((1 << CH_COUNT) - 1);
	localparam logic [WORD_W-1:0] COMM_FORCE_WORD = 16'hffff;
	localparam logic [WORD_W-1:0] WORD_RESET      = 16'h0000;

	// ======================================================================
	// Level to count conversion, slopes in Q16.16, product in Q.32
	// ======================================================================
	localparam logic signed [31:0] SLOPE_MA_Q16  = 32'sh0c05f973; // 3077.9744124443446
	localparam logic signed [31:0] SLOPE_V_Q16   = 32'sh0c44931e; // 3140.5746817972704
	localparam logic signed [PROD_W-1:0] HALF_Q32 = 56'sh0000_0080_000000;
	localparam int PROD_FRAC = 32;
	localparam logic signed [LEVEL_W-1:0] MA_OFFSET = 24'sh008000; // 32768
	localparam logic signed [LEVEL_W-1:0] COUNT_MAX = 24'sh007fff;
	localparam logic signed [LEVEL_W-1:0] COUNT_MIN = 24'shff8000;

endpackage : fault_report_pkg

/* File: design/fault_report.sv */
// Fault, status and data echo reporter for a four or eight channel output module
`timescale 1ns/1ps

module fault_report (
	// Clock and reset
	input  wire logic                                              i_core_clk,
	input  wire logic                                              i_reset_n,
	// Mode, owner link and echo request
	input  wire logic                                              i_float_mode,
	input  wire logic                                              i_comm_fault,
	input  wire logic                                              i_echo_req,
	// Per channel range, level and conditions
	input  wire logic [fault_report_pkg::CH_COUNT-1:0]                 i_range_current,
	input  wire logic [fault_report_pkg::CH_COUNT-1:0][fault_report_pkg::LEVEL_W-1:0] i_level,
	input  wire logic [fault_report_pkg::CH_COUNT-1:0]                 i_high_alarm,
	input  wire logic [fault_report_pkg::CH_COUNT-1:0]                 i_low_alarm,
	input  wire logic [fault_report_pkg::CH_COUNT-1:0]                 i_rate_alarm,
	input  wire logic [fault_report_pkg::CH_COUNT-1:0]                 i_in_hold,
	input  wire logic [fault_report_pkg::CH_COUNT-1:0]                 i_not_number,
	input  wire logic [fault_report_pkg::CH_COUNT-1:0]                 i_cal_active,
	input  wire logic [fault_report_pkg::CH_COUNT-1:0]                 i_cal_error,
	input  wire logic [fault_report_pkg::CH_COUNT-1:0]                 i_loop_open,
	input  wire logic [fault_report_pkg::CH_COUNT-1:0]                 i_above_min_current,
	// Echo pulse and the words published with it
	output logic                                                   o_echo_valid,
	output logic [fault_report_pkg::WORD_W-1:0]                        o_module_fault_summary,
	output logic [fault_report_pkg::WORD_W-1:0]                        o_channel_fault_summary,
	output logic [fault_report_pkg::CH_COUNT-1:0][fault_report_pkg::WORD_W-1:0] o_per_channel_status,
	output logic [fault_report_pkg::CH_COUNT-1:0][fault_report_pkg::WORD_W-1:0] o_echo_counts,
	// Live open circuit flags, not tied to the echo
	output logic [fault_report_pkg::CH_COUNT-1:0]                      o_open_circuit_flag
);
	import fault_report_pkg::*;

	// ======================================================================
	// State
	// ======================================================================
	// Published words are held here between echoes; only the open latch and the
	// echo pulse bit are rewritten every cycle; the latch must follow the loop even with no request
	// Words and counts of one snapshot always come from the same edge
	typedef struct packed {
		logic                               echo_valid;
		logic [WORD_W-1:0]                  module_word;
		logic [WORD_W-1:0]                  chan_word;
		logic [CH_COUNT-1:0][WORD_W-1:0]    status;
		logic [CH_COUNT-1:0][WORD_W-1:0]    counts;
		logic [CH_COUNT-1:0]                open_latch;
	} report_state_t;

	// Registered copy and its next value
	report_state_t state_reg;
	report_state_t state_next;

	// Converted counts, each slice driven by its own channel converter
	wire logic [CH_COUNT-1:0][WORD_W-1:0] count_live;

	// ======================================================================
	// Level to user count conversion, one converter per channel
	// ======================================================================
	// Levels are Q8.16 in mA or V and slopes are Q16.16, so the product
	// carries 32 fraction bits; the integer part is taken from bit 32 up
	// Rounds to nearest so a 2 V request lands on 6281 and 6 mA on -14300
	generate
		for (genvar c = 0; c < CH_COUNT; c++) begin : g_conv
			logic signed [PROD_W-1:0]  prod;
			logic signed [PROD_W-1:0]  acc;
			logic signed [LEVEL_W-1:0] whole;
			logic signed [LEVEL_W-1:0] shifted;
			logic        [WORD_W-1:0]  sat;

			// Slope picked by range; the minus 0.5 of the voltage line cancels the rounding half
			assign prod = PROD_W'($signed(i_level[c])) *
				PROD_W'(i_range_current[c] ? SLOPE_MA_Q16 : SLOPE_V_Q16);
			assign acc     = prod + (i_range_current[c] ? HALF_Q32 : '0);
			// Integer part only; 24 bits cover every level either range can ask for
			assign whole   = acc[PROD_FRAC +: LEVEL_W];
			assign shifted = whole - (i_range_current[c] ? MA_OFFSET : '0);

			// Saturate so an out of range request cannot wrap the count
			always_comb begin
				if (shifted > COUNT_MAX) begin
					sat = COUNT_MAX[WORD_W-1:0];
				end else if (shifted < COUNT_MIN) begin
					sat = COUNT_MIN[WORD_W-1:0];
				end else begin
					sat = shifted[WORD_W-1:0];
				end
			end

			// Each channel drives only its own slice of the shared net
			assign count_live[c] = sat;
		end
	endgenerate

	// ======================================================================
	// Next state
	// ======================================================================
	always_comb begin
		logic [CH_COUNT-1:0]             open_now;
		logic [CH_COUNT-1:0]             chan_bits;
		logic [WORD_W-1:0]               chan_word;
		logic [WORD_W-1:0]               module_word;
		logic [CH_COUNT-1:0][WORD_W-1:0] status;
		open_now    = '0;
		chan_bits   = '0;
		chan_word   = WORD_RESET;
		module_word = WORD_RESET;
		status      = '0;
		state_next  = state_reg;
		state_next.echo_valid = 1'b0;

		// Open circuit: set only when driving above the minimum, held while the loop stays open
		// The flag port shows this every cycle; the status bit only holds the snapshot
		for (int c = 0; c < CH_COUNT; c++) begin
			open_now[c] = i_range_current[c] & i_loop_open[c] &
				(i_above_min_current[c] | state_reg.open_latch[c]);
		end
		state_next.open_latch = open_now;

		// Channel fault bits; integer mode only reports open wire in normal running
		// Voltage channels never reach the word through open wire; open_now masks them
		for (int c = 0; c < CH_COUNT; c++) begin
			if (i_float_mode) begin
				chan_bits[c] = i_high_alarm[c] | i_low_alarm[c] | open_now[c];
			end else begin
				chan_bits[c] = open_now[c];
			end
		end

		// Communication loss outranks calibration since no owner is listening anyway
		// Comm loss fills the whole word and calibration the low CH_COUNT bits, so the summary group bit follows both
		if (i_comm_fault) begin
			chan_word = COMM_FORCE_WORD;
		end else if (|i_cal_active) begin
			chan_word = CAL_FORCE_WORD;
		end else begin
			chan_word = WORD_W'(chan_bits);
		end

		// Summary word, identical in both modes
		// Bits 14-13 and 10-0 stay zero so a nonzero word always means a real fault
		module_word[SUM_GROUP_BIT] = |chan_word;
		module_word[SUM_CAL_BUSY]  = |i_cal_active;
		module_word[SUM_CAL_ERR]   = |i_cal_error;

		// Status words: one per channel in float mode, one packed word in integer mode
		// Four channel build: the packed word fills bits 15-8 only, lower bits read zero
		// Float words leave bit 6 and bits 15-8 at zero; no condition maps there
		if (i_float_mode) begin
			for (int c = 0; c < CH_COUNT; c++) begin
				status[c][ST_HIGH_BIT] = i_high_alarm[c];
				status[c][ST_LOW_BIT]  = i_low_alarm[c];
				status[c][ST_RATE_BIT] = i_rate_alarm[c];
				status[c][ST_HOLD_BIT] = i_in_hold[c];
				status[c][ST_CAL_BIT]  = i_cal_error[c];
				status[c][ST_NAN_BIT]  = i_not_number[c];
				status[c][ST_OPEN_BIT] = open_now[c];
			end
		end else begin
			for (int c = 0; c < CH_COUNT; c++) begin
				status[0][INT_OPEN_TOP - 2 * c] = open_now[c];
				status[0][INT_HOLD_TOP - 2 * c] = i_in_hold[c];
			end
		end

		// Words are snapshotted only with the echoed data so they always travel together
		if (i_echo_req) begin
			state_next.echo_valid  = 1'b1;
			state_next.chan_word   = chan_word;
			state_next.module_word = module_word;
			state_next.status      = status;
			// Float counts pass the low 16 bits of the raw level through; its floating format is packed elsewhere
			for (int c = 0; c < CH_COUNT; c++) begin
				state_next.counts[c] = i_float_mode ? i_level[c][WORD_W-1:0] : count_live[c];
			end
		end
	end

	// ======================================================================
	// Registers
	// ======================================================================
	// Synchronous reset clears every published word, so a restart never
	// republishes faults seen before it
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ======================================================================
	// Outputs
	// ======================================================================
	// All outputs straight from flip-flops; words stand until the next echo
	// The owner must take them on the echo pulse, not between pulses
	assign o_echo_valid            = state_reg.echo_valid;
	assign o_module_fault_summary  = state_reg.module_word;
	assign o_channel_fault_summary = state_reg.chan_word;
	assign o_per_channel_status    = state_reg.status;
	assign o_echo_counts           = state_reg.counts;
	assign o_open_circuit_flag     = state_reg.open_latch;

endmodule : fault_report

/* File: bench/fault_report_assertions.sv */
// Concurrent checks on the fault reporter's published words and open flag
`timescale 1ns/1ps
module fault_report_assertions import fault_report_pkg::*; (
	input wire logic                i_core_clk,
	input wire logic                i_reset_n,
	input wire logic                i_echo_req,
	input wire logic                i_comm_fault,
	input wire logic [CH_COUNT-1:0] i_range_current,
	input wire logic [CH_COUNT-1:0] i_cal_active,
	input wire logic [CH_COUNT-1:0] i_cal_error,
	input wire logic [CH_COUNT-1:0] i_loop_open,
	input wire logic [CH_COUNT-1:0] i_above_min_current,
	input wire logic                o_echo_valid,
	input wire logic [WORD_W-1:0]   o_module_fault_summary,
	input wire logic [WORD_W-1:0]   o_channel_fault_summary,
	input wire logic [CH_COUNT-1:0] o_open_circuit_flag
);
	// ======================================================================
	// Echo timing and summary word
	// ======================================================================
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	a_echo_pulse: assert property (o_echo_valid == $past(i_echo_req & i_reset_n))
		else $error("echo valid not one cycle after request");
	a_group_fault: assert property (o_echo_valid |-> o_module_fault_summary[15] ==
		(|o_channel_fault_summary)) else $error("group bit disagrees with channel word");
	a_cal_busy: assert property (i_echo_req |=> o_module_fault_summary[12] ==
		$past(|i_cal_active)) else $error("calibrating bit wrong");
	a_cal_error: assert property (i_echo_req |=> o_module_fault_summary[11] ==
		$past(|i_cal_error)) else $error("calibration error bit wrong");
	a_unused_zero: assert property (o_echo_valid |-> o_module_fault_summary[14:13] == 2'b00
		&& o_module_fault_summary[10:0] == 11'h000) else $error("unused summary bit set");
	// ======================================================================
	// Channel fault word forcing
	// ======================================================================
	a_comm_force: assert property (i_echo_req && i_comm_fault |=>
		o_channel_fault_summary == 16'hffff) else $error("comm fault word not forced");
	a_cal_force: assert property (i_echo_req && !i_comm_fault && (|i_cal_active) |=>
		o_channel_fault_summary == WORD_W'((1 << CH_COUNT) - 1)) else $error("cal force wrong");
	a_chan_width: assert property (i_echo_req && !i_comm_fault |=>
		(o_channel_fault_summary >> CH_COUNT) == '0) else $error("channel word bit out of range");
	// ======================================================================
	// Open circuit latch, channel 0 stands for all
	// ======================================================================
	a_open_set: assert property (i_range_current[0] && i_loop_open[0] && i_above_min_current[0]
		|=> o_open_circuit_flag[0]) else $error("open flag did not set");
	a_open_clear: assert property (!(i_range_current[0] && i_loop_open[0]) |=>
		!o_open_circuit_flag[0]) else $error("open flag without open current loop");
endmodule : fault_report_assertions

bind fault_report fault_report_assertions chk_i (
	.i_core_clk              (i_core_clk),
	.i_reset_n               (i_reset_n),
	.i_echo_req              (i_echo_req),
	.i_comm_fault            (i_comm_fault),
	.i_range_current         (i_range_current),
	.i_cal_active            (i_cal_active),
	.i_cal_error             (i_cal_error),
	.i_loop_open             (i_loop_open),
	.i_above_min_current     (i_above_min_current),
	.o_echo_valid            (o_echo_valid),
	.o_module_fault_summary  (o_module_fault_summary),
	.o_channel_fault_summary (o_channel_fault_summary),
	.o_open_circuit_flag     (o_open_circuit_flag)
);

/* File: bench/owner_model.sv */
// Owning controller stand-in that keeps the two summary words of each published snapshot
`timescale 1ns/1ps
module owner_model import fault_report_pkg::*; (
	input wire logic              i_core_clk,
	input wire logic              i_echo_valid,
	input wire logic [WORD_W-1:0] i_module_fault_summary,
	input wire logic [WORD_W-1:0] i_channel_fault_summary,
	output logic [WORD_W-1:0]     o_seen_summary,
	output logic [WORD_W-1:0]     o_seen_faults
);
	// Words are only trusted on the echo pulse; between pulses they may be stale
	always_ff @(posedge i_core_clk) begin
		if (i_echo_valid) begin
			o_seen_summary <= i_module_fault_summary;
			o_seen_faults  <= i_channel_fault_summary;
		end
	end
endmodule : owner_model

/* File: bench/fault_report_tb_top.sv */
// Self-checking bench for the fault and status reporter
`timescale 1ns/1ps
module fault_report_tb_top;
	import fault_report_pkg::*;
	logic i_core_clk = 0, i_reset_n = 0, i_float_mode = 1, i_comm_fault = 0, i_echo_req = 0;
	logic [CH_COUNT-1:0] i_range_current = '1, i_high_alarm = 0, i_low_alarm = 0;
	logic [CH_COUNT-1:0] i_rate_alarm = 0, i_in_hold = 0, i_not_number = 0, i_cal_active = 0;
	logic [CH_COUNT-1:0] i_cal_error = 0, i_loop_open = 0, i_above_min_current = 0;
	logic [CH_COUNT-1:0][LEVEL_W-1:0] i_level = '0;
	logic [CH_COUNT-1:0] o_open_circuit_flag;
	logic o_echo_valid;
	logic [WORD_W-1:0] o_module_fault_summary, o_channel_fault_summary, seen_sum, seen_flt;
	logic [CH_COUNT-1:0][WORD_W-1:0] o_per_channel_status, o_echo_counts;
	int errors = 0, cmp_count = 0;
	// ======================================================================
	// Clock, design and owner
	// ======================================================================
	always #4 i_core_clk = ~i_core_clk;
	fault_report DUT (
		.i_core_clk              (i_core_clk),
		.i_reset_n               (i_reset_n),
		.i_float_mode            (i_float_mode),
		.i_comm_fault            (i_comm_fault),
		.i_echo_req              (i_echo_req),
		.i_range_current         (i_range_current),
		.i_level                 (i_level),
		.i_high_alarm            (i_high_alarm),
		.i_low_alarm             (i_low_alarm),
		.i_rate_alarm            (i_rate_alarm),
		.i_in_hold               (i_in_hold),
		.i_not_number            (i_not_number),
		.i_cal_active            (i_cal_active),
		.i_cal_error             (i_cal_error),
		.i_loop_open             (i_loop_open),
		.i_above_min_current     (i_above_min_current),
		.o_echo_valid            (o_echo_valid),
		.o_module_fault_summary  (o_module_fault_summary),
		.o_channel_fault_summary (o_channel_fault_summary),
		.o_per_channel_status    (o_per_channel_status),
		.o_echo_counts           (o_echo_counts),
		.o_open_circuit_flag     (o_open_circuit_flag)
	);
	owner_model owner (.i_core_clk, .i_echo_valid(o_echo_valid),
		.i_module_fault_summary(o_module_fault_summary), .o_seen_summary(seen_sum),
		.i_channel_fault_summary(o_channel_fault_summary), .o_seen_faults(seen_flt));
	// ======================================================================
	// Shared tasks
	// ======================================================================
	task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	// One request pulse, then judge the owner's copy after it lands
	task automatic echo(input logic [WORD_W-1:0] flt, input logic [WORD_W-1:0] sum);
		@(negedge i_core_clk) i_echo_req = 1;
		@(negedge i_core_clk) i_echo_req = 0;
		chk(WORD_W'(o_echo_valid), 16'h0001);
		@(negedge i_core_clk);
		chk(seen_flt, flt);
		chk(seen_sum, sum);
	endtask : echo
	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	// ======================================================================
	// Scenarios
	// ======================================================================
	// Float mode: alarms, open wire on current and voltage channels
	task automatic s_float;
		i_range_current = 8'hfd;
		i_level[4] = 24'h001234;
		{i_high_alarm, i_low_alarm, i_rate_alarm, i_not_number} = 32'h04200880;
		{i_loop_open, i_above_min_current, i_in_hold} = 24'h030340;
		@(negedge i_core_clk);
		echo(16'h0025, 16'h8000);
		chk(o_per_channel_status[0], 16'h0080);
		chk(o_per_channel_status[1], 16'h0000);
		chk(o_per_channel_status[2], 16'h0001);
		chk(o_per_channel_status[3], 16'h0004);
		chk(o_per_channel_status[5], 16'h0002);
		chk(o_per_channel_status[6], 16'h0008);
		chk(o_per_channel_status[7], 16'h0020);
		chk(o_echo_counts[4], 16'h1234);
	endtask : s_float
	// Open flag survives loss of current, clears when the loop closes
	task automatic s_latch;
		i_above_min_current = 8'h00;
		repeat (2) @(negedge i_core_clk);
		chk(WORD_W'(o_open_circuit_flag), 16'h0001);
		i_loop_open = 8'h00;
		@(negedge i_core_clk);
		chk(WORD_W'(o_open_circuit_flag), 16'h0000);
	endtask : s_latch
	// Calibration and comm loss force the channel word; calibration is released first, then comm loss
	task automatic s_cal;
		{i_high_alarm, i_low_alarm, i_rate_alarm, i_not_number} = '0;
		{i_cal_active, i_cal_error} = 16'h1040;
		echo(16'h00ff, 16'h9800);
		chk(o_per_channel_status[6], 16'h0018);
		i_comm_fault = 1;
		echo(16'hffff, 16'h9800);
		i_cal_active = 8'h00;
		echo(16'hffff, 16'h8800);
		i_comm_fault = 0;
		echo(16'h0000, 16'h0800);
	endtask : s_cal
	// Integer mode: counts, packed status word, open-only channel faults
	task automatic s_int;
		{i_float_mode, i_cal_error, i_in_hold, i_high_alarm} = 25'h0000204;
		{i_range_current, i_loop_open, i_above_min_current} = 24'h0d0101;
		i_level[0] = 24'h060000;
		i_level[1] = 24'h020000;
		i_level[2] = 24'h140000;
		@(negedge i_core_clk);
		echo(16'h0001, 16'h8000);
		chk(o_echo_counts[0], 16'hc824);
		chk(o_echo_counts[2], 16'h7077);
		chk(o_echo_counts[3], 16'h8000);
		chk(o_echo_counts[1], 16'h1889);
		chk(o_per_channel_status[0], 16'h9000);
		chk(o_per_channel_status[1], 16'h0000);
	endtask : s_int
	// ======================================================================
	// Main sequence and watchdog
	// ======================================================================
	initial begin
		repeat (6) @(negedge i_core_clk);
		i_reset_n = 1;
		@(negedge i_core_clk);
		chk(o_channel_fault_summary, 16'h0000);
		s_float();
		s_latch();
		s_cal();
		s_int();
		summarize();
	end
	initial begin
		#(2000 * 8);
		errors++;
		summarize();
	end
endmodule : fault_report_tb_top
